/* File: tcf_pkg.sv */
// package: register map, field layout and carrier types of the timer control
package tcf_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MAX_CH = 6;
    localparam int unsigned DIV_W  = 7;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FORCE  = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTRL2  = 8'h0D;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0E;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned CTRL2_OVF_IE_BIT = 7;
    localparam int unsigned CTRL2_DIV_LSB    = 0;
    localparam int unsigned DIV_SEL_W        = 3;
    localparam int unsigned STATUS_OVF_BIT   = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] RST_MODE   = 8'h00;
    localparam logic [DATA_W-1:0] RST_IRQ_EN = 8'h00;
    localparam logic [DATA_W-1:0] RST_CTRL2  = 8'h00;
    localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
    localparam logic [DATA_W-1:0] RST_RDATA  = 8'h00;
    localparam logic [DIV_W-1:0]  RST_DIV    = 7'h00;
    localparam logic [DATA_W-1:0] FORCE_READ = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED   = 8'h00;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tcf_bus_s;

    typedef struct packed {
        logic [MAX_CH-1:0] compare_match;
        logic [MAX_CH-1:0] capture_edge;
        logic              counter_wrap;
    } tcf_evt_s;

    typedef struct packed {
        logic [MAX_CH-1:0] compare_action;
        logic [MAX_CH-1:0] compare_mode;
        logic              prescale_tick;
    } tcf_ctl_s;

endpackage : tcf_pkg

/* File: tcf_timer_ctl.sv */
// module: timer compare force, interrupt enables and prescaler selection
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module tcf_timer_ctl #(
    parameter int unsigned NUM_CH = tcf_pkg::MAX_CH
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire tcf_pkg::tcf_bus_s bus,
    input  wire tcf_pkg::tcf_evt_s evt,
    output var  logic [tcf_pkg::DATA_W-1:0] rd_data,
    output var  tcf_pkg::tcf_ctl_s ctl,
    output var  logic            irq
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (NUM_CH < 1 || NUM_CH > tcf_pkg::MAX_CH) begin : g_bad_ch
        $error("tcf_timer_ctl: NUM_CH must be 1 to 6");
    end

    // code 7 needs a full 7-bit count, or the slowest ratio falls short
    if (tcf_pkg::DIV_W < (1 << tcf_pkg::DIV_SEL_W) - 1) begin : g_bad_div
        $error("tcf_timer_ctl: divider count too narrow for code 7");
    end

    // overflow flag must sit above the channel flags, inside the byte
    if (tcf_pkg::STATUS_OVF_BIT < tcf_pkg::MAX_CH ||
        tcf_pkg::STATUS_OVF_BIT >= tcf_pkg::DATA_W) begin : g_bad_ovf
        $error("tcf_timer_ctl: overflow flag overlaps channel flags");
    end

    // divide field must stay below the overflow enable bit
    if (tcf_pkg::CTRL2_DIV_LSB + tcf_pkg::DIV_SEL_W >
        tcf_pkg::CTRL2_OVF_IE_BIT ||
        tcf_pkg::CTRL2_OVF_IE_BIT >= tcf_pkg::DATA_W) begin : g_bad_ctrl2
        $error("tcf_timer_ctl: control two fields overlap");
    end

    // local copies of the widths, so size casts need no package scope
    localparam int unsigned CH_W  = tcf_pkg::MAX_CH;
    localparam int unsigned CNT_W = tcf_pkg::DIV_W;

    localparam logic [CH_W-1:0] CH_MASK = CH_W'((1 << NUM_CH) - 1);

    // ************************************************************
    // address decode
    // ************************************************************
    logic sel_mode;
    logic sel_force;
    logic sel_irq_en;
    logic sel_ctrl2;
    logic sel_status;

    always_comb begin
        sel_mode   = 1'b0;
        sel_force  = 1'b0;
        sel_irq_en = 1'b0;
        sel_ctrl2  = 1'b0;
        sel_status = 1'b0;
        if (bus.addr == tcf_pkg::OFF_MODE) begin
            sel_mode = 1'b1;
        end else if (bus.addr == tcf_pkg::OFF_FORCE) begin
            sel_force = 1'b1;
        end else if (bus.addr == tcf_pkg::OFF_IRQ_EN) begin
            sel_irq_en = 1'b1;
        end else if (bus.addr == tcf_pkg::OFF_CTRL2) begin
            sel_ctrl2 = 1'b1;
        end else if (bus.addr == tcf_pkg::OFF_STATUS) begin
            sel_status = 1'b1;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [tcf_pkg::MAX_CH-1:0]    mode_q;
    logic [tcf_pkg::MAX_CH-1:0]    mode_d;
    logic [tcf_pkg::MAX_CH-1:0]    irq_en_q;
    logic [tcf_pkg::MAX_CH-1:0]    irq_en_d;
    logic                          ovf_ie_q;
    logic                          ovf_ie_d;
    logic [tcf_pkg::DIV_SEL_W-1:0] div_sel_q;
    logic [tcf_pkg::DIV_SEL_W-1:0] div_sel_d;

    always_comb begin
        mode_d    = mode_q;
        irq_en_d  = irq_en_q;
        ovf_ie_d  = ovf_ie_q;
        div_sel_d = div_sel_q;
        if (bus.wr && sel_mode) begin
            mode_d = bus.wdata[tcf_pkg::MAX_CH-1:0] & CH_MASK;
        end
        if (bus.wr && sel_irq_en) begin
            irq_en_d = bus.wdata[tcf_pkg::MAX_CH-1:0] & CH_MASK;
        end
        if (bus.wr && sel_ctrl2) begin
            ovf_ie_d  = bus.wdata[tcf_pkg::CTRL2_OVF_IE_BIT];
            div_sel_d = bus.wdata[tcf_pkg::CTRL2_DIV_LSB +:
                                  tcf_pkg::DIV_SEL_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q    <= tcf_pkg::RST_MODE[tcf_pkg::MAX_CH-1:0];
            irq_en_q  <= tcf_pkg::RST_IRQ_EN[tcf_pkg::MAX_CH-1:0];
            ovf_ie_q  <= tcf_pkg::RST_CTRL2[tcf_pkg::CTRL2_OVF_IE_BIT];
            div_sel_q <= tcf_pkg::RST_CTRL2[tcf_pkg::CTRL2_DIV_LSB +:
                                            tcf_pkg::DIV_SEL_W];
        end else begin
            mode_q    <= mode_d;
            irq_en_q  <= irq_en_d;
            ovf_ie_q  <= ovf_ie_d;
            div_sel_q <= div_sel_d;
        end
    end

    // ************************************************************
    // compare force and compare action
    // ************************************************************
    // the force strobe is never stored: it lives only in the write cycle
    logic [tcf_pkg::MAX_CH-1:0] force_now;
    logic [tcf_pkg::MAX_CH-1:0] real_match;
    logic [tcf_pkg::MAX_CH-1:0] action_d;
    logic [tcf_pkg::MAX_CH-1:0] action_q;

    always_comb begin
        force_now = '0;
        if (bus.wr && sel_force) begin
            force_now = bus.wdata[tcf_pkg::MAX_CH-1:0] & CH_MASK;
        end
        // input capture channels have no pin action to force
        force_now  = force_now & mode_q;
        real_match = evt.compare_match & mode_q & CH_MASK;
        // same pin effect either way, so one strobe serves both causes
        action_d   = force_now | real_match;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            action_q <= '0;
        end else begin
            action_q <= action_d;
        end
    end

    // ************************************************************
    // event flags, read clears, set wins
    // ************************************************************
    logic [tcf_pkg::MAX_CH-1:0] ch_flag_q;
    logic [tcf_pkg::MAX_CH-1:0] ch_flag_d;
    logic [tcf_pkg::MAX_CH-1:0] ch_set;
    logic                       ovf_flag_q;
    logic                       ovf_flag_d;
    logic                       clr_status;

    // a read and an event in one cycle: the event survives
    always_comb begin
        clr_status = bus.rd && sel_status;
        // a forced channel sets no flag, even with a real match beside it
        ch_set = (real_match & ~force_now)
               | (evt.capture_edge & ~mode_q & CH_MASK);
        ch_flag_d  = ch_flag_q;
        ovf_flag_d = ovf_flag_q;
        if (clr_status) begin
            ch_flag_d  = '0;
            ovf_flag_d = 1'b0;
        end
        ch_flag_d  = ch_flag_d | ch_set;
        ovf_flag_d = ovf_flag_d | evt.counter_wrap;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch_flag_q  <= tcf_pkg::RST_STATUS[tcf_pkg::MAX_CH-1:0];
            ovf_flag_q <= tcf_pkg::RST_STATUS[tcf_pkg::STATUS_OVF_BIT];
        end else begin
            ch_flag_q  <= ch_flag_d;
            ovf_flag_q <= ovf_flag_d;
        end
    end

    // ************************************************************
    // interrupt output
    // ************************************************************
    // taken from next-state values so the output itself is a flop
    // level output: it stays high until software reads the status or clears the matching enable bit
    logic irq_d;
    logic irq_q;

    always_comb begin
        irq_d = (|(ch_flag_d & irq_en_d))
              | (ovf_flag_d & ovf_ie_d);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ************************************************************
    // prescaler
    // ************************************************************
    logic [tcf_pkg::DIV_W-1:0] div_cnt_q;
    logic [tcf_pkg::DIV_W-1:0] div_cnt_d;
    logic [tcf_pkg::DIV_W-1:0] div_mask;
    logic                      tick_d;
    logic                      tick_q;

    always_comb begin
        // code n keeps n low bits, so a tick falls every 2**n cycles
        // limitation: the tick is one bus cycle wide for codes 1 to 7; at code 0 it stays high every cycle
        div_mask  = CNT_W'((1 << div_sel_q) - 1);
        tick_d    = ((div_cnt_q & div_mask) == div_mask);
        div_cnt_d = div_cnt_q + CNT_W'(1);
        // a new code restarts the count so the first period is whole
        if (bus.wr && sel_ctrl2) begin
            div_cnt_d = tcf_pkg::RST_DIV;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_q <= tcf_pkg::RST_DIV;
            tick_q    <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            tick_q    <= tick_d;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [tcf_pkg::DATA_W-1:0] rdata_d;
    logic [tcf_pkg::DATA_W-1:0] rdata_q;

    always_comb begin
        rdata_d = rdata_q;
        if (bus.rd) begin
            rdata_d = tcf_pkg::UNMAPPED;
            if (sel_mode) begin
                rdata_d = {{(tcf_pkg::DATA_W-tcf_pkg::MAX_CH){1'b0}},
                           mode_q};
            end else if (sel_force) begin
                rdata_d = tcf_pkg::FORCE_READ;
            end else if (sel_irq_en) begin
                rdata_d = {{(tcf_pkg::DATA_W-tcf_pkg::MAX_CH){1'b0}},
                           irq_en_q};
            end else if (sel_ctrl2) begin
                rdata_d = '0;
                rdata_d[tcf_pkg::CTRL2_OVF_IE_BIT] = ovf_ie_q;
                rdata_d[tcf_pkg::CTRL2_DIV_LSB +: tcf_pkg::DIV_SEL_W] =
                    div_sel_q;
            end else if (sel_status) begin
                rdata_d = '0;
                rdata_d[tcf_pkg::MAX_CH-1:0]      = ch_flag_q;
                rdata_d[tcf_pkg::STATUS_OVF_BIT] = ovf_flag_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= tcf_pkg::RST_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        rd_data                = rdata_q;
        irq                    = irq_q;
        ctl.compare_action     = action_q;
        ctl.compare_mode       = mode_q;
        ctl.prescale_tick      = tick_q;
    end

endmodule : tcf_timer_ctl

`default_nettype wire

/* File: tcf_timer_ctl_monitor.sv */
// checker: port properties of the timer control block
`timescale 1ns/1ps
`default_nettype none
module tcf_timer_ctl_monitor #(
    parameter int unsigned NUM_CH = tcf_pkg::MAX_CH
) (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire tcf_pkg::tcf_bus_s           bus,
    input wire tcf_pkg::tcf_evt_s           evt,
    input wire logic [tcf_pkg::DATA_W-1:0]  rd_data,
    input wire tcf_pkg::tcf_ctl_s           ctl,
    input wire logic                        irq
);
    // ************************
    // enable shadows
    // ************************
    logic       fw;
    logic [5:0] en_q, en_d;
    logic       ov_q, ov_d;
    assign fw = bus.wr && bus.addr == 8'h01;
    always_comb begin
        en_d = en_q;
        ov_d = ov_q;
        if (bus.wr && bus.addr == 8'h0C) begin
            en_d = bus.wdata[5:0] & 6'((1 << NUM_CH) - 1);
        end
        if (bus.wr && bus.addr == 8'h0D) begin
            ov_d = bus.wdata[7];
        end
    end
    always_ff @(posedge clk) begin
        {en_q, ov_q} <= rst_n ? {en_d, ov_d} : 7'h00;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_force_zero;
        bus.rd && bus.addr == 8'h01 |=> rd_data == 8'h00;
    endproperty
    a_force_zero: assert property (p_force_zero)
        else $error("force register read nonzero");
    property p_force_act;
        fw && evt.compare_match == 6'h00 |=> ctl.compare_action ==
            ($past(bus.wdata[5:0]) & $past(ctl.compare_mode));
    endproperty
    a_force_act: assert property (p_force_act)
        else $error("forced action wrong");
    property p_match_act;
        !fw |=> ctl.compare_action ==
            ($past(evt.compare_match) & $past(ctl.compare_mode));
    endproperty
    a_match_act: assert property (p_match_act)
        else $error("match action wrong");
    // only forced channels may match, so no flag can appear
    property p_force_quiet;
        fw && !irq && evt.capture_edge == 6'h00 && !evt.counter_wrap &&
            (evt.compare_match & ~bus.wdata[5:0]) == 6'h00 |=> !irq;
    endproperty
    a_force_quiet: assert property (p_force_quiet)
        else $error("force raised a flag");
    property p_read_clear;
        bus.rd && bus.addr == 8'h0E && evt == '0 |=> !irq;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("irq after status read");
    property p_chan_irq;
        !bus.wr && (evt.compare_match & ctl.compare_mode & en_q) != 6'h00
            |=> irq;
    endproperty
    a_chan_irq: assert property (p_chan_irq)
        else $error("enabled event gave no irq");
    property p_ovf_irq;
        !bus.wr && evt.counter_wrap && ov_q |=> irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow gave no irq");
    property p_masked;
        !irq && !bus.wr && en_q == 6'h00 && !ov_q |=> !irq;
    endproperty
    a_masked: assert property (p_masked)
        else $error("irq while all masked");
    cover property (fw && evt.compare_match != 6'h00);
    cover property (evt.counter_wrap && ov_q);
    cover property (bus.rd && bus.addr == 8'h0E && irq);
endmodule : tcf_timer_ctl_monitor
`default_nettype wire

/* File: tcf_timer_ctl_tb.sv */
// testbench: registers, force, events, interrupts, prescaler
`timescale 1ns/1ps
`default_nettype none
module tcf_timer_ctl_tb;
    logic              clk;
    logic              rst_n;
    logic              irq;
    logic [7:0]        rd_data;
    tcf_pkg::tcf_bus_s bus;
    tcf_pkg::tcf_evt_s evt;
    tcf_pkg::tcf_ctl_s ctl;
    int                n_fail = 0;
    int                total_checks = 0;
    int                g;
    int                n;
    tcf_timer_ctl tcf_timer_ctl_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
        .evt(evt), .rd_data(rd_data), .ctl(ctl), .irq(irq));
    // ************************
    // access tasks
    // ************************
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    // one strobe with events beside it, then idle
    task automatic cyc(input logic w, r, input logic [7:0] a, d,
                       input logic [5:0] m, c, input logic o);
        @(posedge clk);
        bus <= '{a, d, w, r};
        evt <= '{m, c, o};
        @(posedge clk);
        bus <= '0;
        evt <= '0;
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, d);
        cyc(1'b1, 1'b0, a, d, 6'h00, 6'h00, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        cyc(1'b0, 1'b1, a, 8'h00, 6'h00, 6'h00, 1'b0);
        chk(rd_data, e);
    endtask : rd
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // tests need about 1000 cycles; twenty times that is a hang
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        bus = '0;
        evt = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h0C, 8'h00);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h3F);
        wr(8'h00, 8'hFF);
        chk(8'(ctl.compare_mode), 8'h3F);
        rd(8'h01, 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        wr(8'h0D, 8'h87);
        rd(8'h0D, 8'h87);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wr(8'h01, 8'h01 << i);
            chk(8'(ctl.compare_action), 8'h01 << i);
            chk(8'(irq), 8'h00);
        end
        rd(8'h0E, 8'h00);
        cyc(1'b1, 1'b0, 8'h01, 8'h04, 6'h04, 6'h00, 1'b0);
        chk(8'(ctl.compare_action), 8'h04);
        rd(8'h0E, 8'h00);
        wr(8'h00, 8'h15);
        wr(8'h01, 8'h3F);
        chk(8'(ctl.compare_action), 8'h15);
        $display("test force done");
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 6'h06, 6'h0C, 1'b0);
        chk(8'(ctl.compare_action), 8'h04);
        chk(8'(irq), 8'h01);
        rd(8'h0E, 8'h0C);
        rd(8'h0E, 8'h00);
        chk(8'(irq), 8'h00);
        wr(8'h0C, 8'h08);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 6'h00, 6'h02, 1'b0);
        chk(8'(irq), 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 6'h00, 6'h08, 1'b0);
        chk(8'(irq), 8'h01);
        rd(8'h0E, 8'h0A);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 6'h00, 6'h00, 1'b1);
        chk(8'(irq), 8'h01);
        rd(8'h0E, 8'h80);
        wr(8'h0D, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 6'h00, 6'h00, 1'b1);
        chk(8'(irq), 8'h00);
        // everything masked: flags still gather, the pin stays low
        wr(8'h0C, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 6'h3F, 6'h3F, 1'b1);
        chk(8'(ctl.compare_action), 8'h15);
        chk(8'(irq), 8'h00);
        rd(8'h0E, 8'hBF);
        $display("test events done");
        // the write restarts the count, but for one cycle after it the tick flop still follows the old phase
        for (int c = 0; c < 8; c++) begin
            wr(8'h0D, 8'(c));
            g = 0;
            n = 0;
            while (n < 3 && g < 300) begin
                @(posedge clk);
                #1;
                g++;
                if (ctl.prescale_tick === 1'b1) begin
                    n++;
                    if (n == 3) chk(8'(g), 8'h01 << c);
                    g = 0;
                end
            end
            chk(8'(n), 8'h03);
        end
        $display("test prescaler done");
        conclude();
    end
endmodule : tcf_timer_ctl_tb
bind tcf_timer_ctl tcf_timer_ctl_monitor #(.NUM_CH(NUM_CH))
    tcf_timer_ctl_monitor_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
    .evt(evt), .rd_data(rd_data), .ctl(ctl), .irq(irq));
`default_nettype wire
